// ==== logic/rscc_pkg.sv ====
// Constants, register map and carrier types of the reset source controller.
// Assumes a single 125 MHz system clock that also stands for the fc clock.
package rscc_pkg;

  // ==========================================================================
  // Register map (word index, byte address is index * 4)
  localparam logic [5:0] REG_IDX_CAUSE = 6'h19;
  localparam logic [5:0] REG_IDX_WDC   = 6'h1a;
  localparam logic [5:0] REG_IDX_SYSC  = 6'h1b;

  // ==========================================================================
  // Field positions
  localparam int CAUSE_CLR_BIT   = 7;
  localparam int CAUSE_TRIM_BIT  = 5;
  localparam int CAUSE_LVL2_BIT  = 4;
  localparam int CAUSE_LVL1_BIT  = 3;
  localparam int CAUSE_CLK_BIT   = 2;
  localparam int CAUSE_WDT_BIT   = 1;
  localparam int CAUSE_TRAP_BIT  = 0;
  localparam int WDC_RAMTRAP_BIT = 0;
  localparam int WDC_TRAPIRQ_BIT = 1;
  localparam int WDC_AREA_BIT    = 2;
  localparam int SYSC_HI_EN_BIT  = 7;
  localparam int SYSC_LO_EN_BIT  = 6;
  localparam int SYSC_LO_SEL_BIT = 5;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [2:0] WDC_RESET   = 3'h0;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;

  // ==========================================================================
  // Address areas that trap an instruction fetch
  localparam logic [15:0] SFR_LO = 16'h0000;
  localparam logic [15:0] SFR_HI = 16'h003f;
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h083f;
  localparam logic [15:0] DBR_LO = 16'h0f80;
  localparam logic [15:0] DBR_HI = 16'h0fff;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int MAL_RST_PERIODS  = 24;
  localparam int MAL_RST_TIME_PS  = MAL_RST_PERIODS * CLK_PERIOD_PS;
  localparam int MAL_RST_CYC      = MAL_RST_TIME_PS / CLK_PERIOD_PS;
  localparam int EXT_MIN_PERIODS  = 12;
  localparam int POWUP_CYC_DEF    = 1000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic irq_clear;
    logic timing_clear;
    logic wdt_enable;
    logic vltd_disable;
  } rscc_init_t;

  typedef struct packed {
    logic hi_en;
    logic lo_en;
    logic lo_sel;
  } rscc_osc_t;

endpackage : rscc_pkg

// ==== logic/rscc_sync.sv ====
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs are quasi-static compared with the system clock.
`timescale 1ns/1ps
module rscc_sync #(
  parameter int            W   = 1,
  parameter logic [W-1:0]  INI = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  // ==========================================================================
  // Stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= INI;
      dout     <= INI;
    end else if (ce) begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : rscc_sync

// ==== logic/rscc_stretch.sv ====
// Stretches a trigger into a busy level of a fixed number of cycles.
// Assumes retriggering restarts the count; busy may start set after reset.
`timescale 1ns/1ps
module rscc_stretch #(
  parameter int CW      = 16,
  parameter int LEN     = 24,
  parameter bit RST_BSY = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic trig,
  output logic      busy
);
  localparam logic [CW-1:0] LOAD = CW'(LEN - 1);
  localparam logic [CW-1:0] INI  = RST_BSY ? LOAD : '0;
  logic [CW-1:0] cnt_reg;
  logic          run_reg;

  // ==========================================================================
  // Counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= INI;
      run_reg <= RST_BSY;
    end else if (ce) begin
      if (trig) begin
        cnt_reg <= LOAD;
        run_reg <= 1'b1;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - CW'(1);
      end else begin
        run_reg <= 1'b0;
      end
    end
  end

  assign busy = trig | run_reg;
endmodule : rscc_stretch

// ==== logic/rscc_top.sv ====
// Reset source controller: gathers reset causes, builds the internal reset,
// records the cause and exposes its registers over Avalon-MM.
// Assumes one 125 MHz clock, RST_B from the power-on level, CPU fetch bus on
// the same clock and asynchronous pin and voltage-detector levels.
//
// Behaviour
// - Malfunction requests put the device into reset within 24 fc periods.
// - Power-on and trim requests hold reset until warm-up fully elapses.
// - Pin high releases reset; execution starts from vector at FFFEH.
// - Every reset clears interrupt master, individual enables and latches.
// - Reset clears prescaler, enables watchdog, disables voltage detection.
// - Fetch from debug, special function, or enabled RAM area traps.
// - Trap response reset or interrupt, and trapped area, are selectable.
// - Clearing both oscillator enables in one write gives clock reset.
// - Clearing high oscillator enable while high clock selected gives reset.
// - Selecting low clock while low oscillator disabled gives clock reset.
// - A clock reset leaves the oscillators running.
// - Supply below voltage threshold gives an internal reset.
// - Trim bits latched during warm-up; corrupt data gives trim reset.
// - Each cause flag sets on its reset and survives reset release.
// - Flags clear on write one to clear bit or reset pin low.
// - Cause register: clear 7, trim 5, level 4/3, clock 2, wdt 1, trap 0.
// - After reset, operation resumes on the high-frequency clock only.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module rscc_top #(
  parameter int POWUP_CYC = rscc_pkg::POWUP_CYC_DEF
) (
  input  wire logic                CLK_SYS,
  input  wire logic                RST_B,
  input  wire logic                CE,
  input  wire logic [7:0]          AVS_ADDRESS,
  input  wire logic                AVS_READ,
  input  wire logic                AVS_WRITE,
  input  wire logic [31:0]         AVS_WRITEDATA,
  output logic      [31:0]         AVS_READDATA,
  output logic                     AVS_WAITREQUEST,
  input  wire logic                RESET_PIN_B,
  input  wire logic                POR_REQ,
  input  wire logic                VLT_ONE_REQ,
  input  wire logic                VLT_TWO_REQ,
  input  wire logic                WDT_REQ,
  input  wire logic                FETCH_STROBE,
  input  wire logic [15:0]         FETCH_ADDR,
  input  wire logic [7:0]          TRIM_DATA,
  input  wire logic                TRIM_PARITY,
  output logic                     SYS_RESET_B,
  output rscc_pkg::rscc_init_t     CORE_INIT,
  output rscc_pkg::rscc_osc_t      OSC_CTRL,
  output logic      [15:0]         RESET_VECTOR,
  output logic      [7:0]          TRIM_VALUE,
  output logic                     ATRAP_IRQ
);
  import rscc_pkg::*;

  // ==========================================================================
  // Decoding helpers
  function automatic logic in_area(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    in_area = (a >= lo) && (a <= hi);
  endfunction : in_area

  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    hit = (a[7:2] == idx) && (a[1:0] == 2'b00);
  endfunction : hit

  logic [2:0]  async_sync;
  logic        pin_b;
  logic        por_s;
  logic        vlt1_s;
  logic        vlt2_s;
  logic        ack_reg;
  logic        req;
  logic        wr_ack;
  logic [7:0]  wdat;
  logic [7:0]  cause_reg;
  logic [2:0]  wdc_reg;
  rscc_osc_t   osc_reg;
  rscc_osc_t   osc_next;
  logic        clk_fault;
  logic        trap_hit;
  logic        trap_rst;
  logic        malf_trig;
  logic        malf_busy;
  logic        warm_busy;
  logic        trim_bad;
  logic        trim_done_reg;
  logic        rst_req;
  logic        rst_meta_reg;
  logic        int_rst_b_reg;
  logic [31:0] rdata_reg;
  logic        trap_irq_reg;
  logic [7:0]  trim_reg;
  logic        clr_req;
  logic [7:0]  cause_set;

  // ==========================================================================
  // Pin and detector synchronisers
  rscc_sync #(.W(3), .INI(3'b000)) u_sync_lvl (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .ce    (CE),
    .din   ({POR_REQ, VLT_ONE_REQ, VLT_TWO_REQ}),
    .dout  (async_sync)
  );
  assign por_s  = async_sync[2];
  assign vlt1_s = async_sync[1];
  assign vlt2_s = async_sync[0];

  rscc_sync #(.W(1), .INI(1'b1)) u_sync_pin (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .ce    (CE),
    .din   (RESET_PIN_B),
    .dout  (pin_b)
  );

  // ==========================================================================
  // Avalon slave: one wait cycle, then the answer
  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_reg;
  assign wr_ack          = AVS_WRITE & ack_reg;
  assign wdat            = AVS_WRITEDATA[7:0];
  assign AVS_READDATA    = rdata_reg;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ack_reg <= 1'b0;
    end else if (CE) begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rdata_reg <= 32'h0000_0000;
    end else if (CE && AVS_READ && !ack_reg) begin
      if (hit(AVS_ADDRESS, REG_IDX_CAUSE)) begin
        rdata_reg <= {24'h00_0000, 1'b0, 1'b0, cause_reg[5:0]};
      end else if (hit(AVS_ADDRESS, REG_IDX_WDC)) begin
        rdata_reg <= {29'h0000_0000, wdc_reg};
      end else if (hit(AVS_ADDRESS, REG_IDX_SYSC)) begin
        rdata_reg <= {24'h00_0000, osc_reg.hi_en, osc_reg.lo_en, osc_reg.lo_sel,
                      5'h00};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Trap control register (reset value selects a reset response)
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      wdc_reg <= WDC_RESET;
    end else if (CE) begin
      if (!int_rst_b_reg) begin
        wdc_reg <= WDC_RESET;
      end else if (wr_ack && hit(AVS_ADDRESS, REG_IDX_WDC)) begin
        wdc_reg <= wdat[2:0];
      end
    end
  end

  // ==========================================================================
  // Oscillator control and clock fault detection
  always_comb begin
    osc_next.hi_en  = wdat[SYSC_HI_EN_BIT];
    osc_next.lo_en  = wdat[SYSC_LO_EN_BIT];
    osc_next.lo_sel = wdat[SYSC_LO_SEL_BIT];
  end

  assign clk_fault = wr_ack && hit(AVS_ADDRESS, REG_IDX_SYSC) &&
                     ((!osc_next.hi_en && !osc_next.lo_en) ||
                      (!osc_next.hi_en && !osc_next.lo_sel) ||
                      (osc_next.lo_sel && !osc_next.lo_en));

  // A faulty write is dropped so the oscillators keep their state
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      osc_reg <= '{hi_en: 1'b1, lo_en: 1'b0, lo_sel: 1'b0};
    end else if (CE) begin
      if (!int_rst_b_reg) begin
        osc_reg.hi_en  <= 1'b1;
        osc_reg.lo_sel <= 1'b0;
      end else if (wr_ack && hit(AVS_ADDRESS, REG_IDX_SYSC) && !clk_fault) begin
        osc_reg <= osc_next;
      end
    end
  end
  assign OSC_CTRL = osc_reg;

  // ==========================================================================
  // Address trap
  assign trap_hit = FETCH_STROBE && int_rst_b_reg &&
                    (in_area(FETCH_ADDR, SFR_LO, SFR_HI) ||
                     (!wdc_reg[WDC_AREA_BIT] && in_area(FETCH_ADDR, DBR_LO, DBR_HI)) ||
                     (wdc_reg[WDC_RAMTRAP_BIT] &&
                      in_area(FETCH_ADDR, RAM_LO, RAM_HI)));
  assign trap_rst = trap_hit & ~wdc_reg[WDC_TRAPIRQ_BIT];

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      trap_irq_reg <= 1'b0;
    end else if (CE) begin
      trap_irq_reg <= trap_hit & wdc_reg[WDC_TRAPIRQ_BIT];
    end
  end
  assign ATRAP_IRQ = trap_irq_reg;

  // ==========================================================================
  // Malfunction reset, held a fixed short time
  assign malf_trig = trap_rst | WDT_REQ | clk_fault | vlt1_s | vlt2_s;

  rscc_stretch #(.CW(8), .LEN(MAL_RST_CYC), .RST_BSY(1'b0)) u_malf (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .ce    (CE),
    .trig  (malf_trig),
    .busy  (malf_busy)
  );

  // ==========================================================================
  // Power-on warm-up and trim load
  assign trim_bad = warm_busy && !trim_done_reg && ((^TRIM_DATA) != TRIM_PARITY);

  rscc_stretch #(.CW(32), .LEN(POWUP_CYC), .RST_BSY(1'b1)) u_warm (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .ce    (CE),
    .trig  (por_s | trim_bad),
    .busy  (warm_busy)
  );

  // Trim is read once per warm-up; a bad read restarts the warm-up
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      trim_done_reg <= 1'b0;
      trim_reg      <= 8'h00;
    end else if (CE) begin
      if (por_s) begin
        trim_done_reg <= 1'b0;
      end else if (warm_busy && !trim_done_reg && !trim_bad) begin
        trim_done_reg <= 1'b1;
        trim_reg      <= TRIM_DATA;
      end
    end
  end
  assign TRIM_VALUE = trim_reg;

  // ==========================================================================
  // Internal reset: async assert from RST_B only, requests assert on the next edge, two-stage synchronous release
  assign rst_req = !pin_b || malf_busy || warm_busy;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_reg  <= 1'b0;
      int_rst_b_reg <= 1'b0;
    end else if (CE) begin
      if (rst_req) begin
        rst_meta_reg  <= 1'b0;
        int_rst_b_reg <= 1'b0;
      end else begin
        rst_meta_reg  <= 1'b1;
        int_rst_b_reg <= rst_meta_reg;
      end
    end
  end
  assign SYS_RESET_B  = int_rst_b_reg;
  assign RESET_VECTOR = RESET_VECTOR_ADDR;

  // Core state cleared or forced while the internal reset is active
  assign CORE_INIT.irq_clear    = !int_rst_b_reg;
  assign CORE_INIT.timing_clear = !int_rst_b_reg;
  assign CORE_INIT.wdt_enable   = !int_rst_b_reg;
  assign CORE_INIT.vltd_disable = !int_rst_b_reg;

  // ==========================================================================
  // Cause flags: a set in the clearing cycle wins
  assign clr_req = !pin_b ||
                   (wr_ack && hit(AVS_ADDRESS, REG_IDX_CAUSE) &&
                    wdat[CAUSE_CLR_BIT]);

  always_comb begin
    cause_set                 = 8'h00;
    cause_set[CAUSE_TRIM_BIT] = trim_bad;
    cause_set[CAUSE_LVL2_BIT] = vlt2_s;
    cause_set[CAUSE_LVL1_BIT] = vlt1_s;
    cause_set[CAUSE_CLK_BIT]  = clk_fault;
    cause_set[CAUSE_WDT_BIT]  = WDT_REQ;
    cause_set[CAUSE_TRAP_BIT] = trap_rst;
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cause_reg <= CAUSE_RESET;
    end else if (CE) begin
      if (clr_req) begin
        cause_reg <= cause_set;
      end else begin
        cause_reg <= cause_reg | cause_set;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK_SYS iff CE);
  endclocking
  default disable iff (!RST_B);

  sequence s_fault_write;
    clk_fault;
  endsequence

  sequence s_reset_seen;
    ##[1:2] !SYS_RESET_B;
  endsequence

  chk_malf_entry: assert property (malf_trig |-> ##[1:24] !SYS_RESET_B)
    else $error("malfunction did not reset in time");

  chk_warm_hold: assert property (warm_busy |=> !SYS_RESET_B)
    else $error("reset released during warm-up");

  chk_clk_reset: assert property (s_fault_write |-> s_reset_seen)
    else $error("clock fault did not reset");

  chk_clk_flag: assert property (s_fault_write |=> cause_reg[CAUSE_CLK_BIT])
    else $error("clock fault flag not set");

  chk_osc_kept: assert property (s_fault_write |=> osc_reg == $past(osc_reg))
    else $error("clock fault changed oscillators");

  chk_flag_sticky: assert property (WDT_REQ |=> cause_reg[CAUSE_WDT_BIT] [*2]
                                    or (cause_reg[CAUSE_WDT_BIT] ##1 $past(clr_req)))
    else $error("watchdog flag lost");

  chk_flag_clear: assert property (clr_req && cause_set == 8'h00 |=> cause_reg == 8'h00)
    else $error("cause flags not cleared");

  chk_clr_reads_zero: assert property (!AVS_WAITREQUEST && AVS_READ
                                       && hit(AVS_ADDRESS, REG_IDX_CAUSE)
                                       |-> AVS_READDATA[7:6] == 2'b00
                                       && AVS_READDATA[5:0] == $past(cause_reg[5:0]))
    else $error("clear bit read as one");

  chk_trap_irq: assert property (trap_hit && wdc_reg[WDC_TRAPIRQ_BIT]
                                 |=> ATRAP_IRQ && (!cause_reg[CAUSE_TRAP_BIT]
                                                   || $past(cause_reg[CAUSE_TRAP_BIT])))
    else $error("trap interrupt not raised");

  chk_high_clock: assert property ($rose(SYS_RESET_B)
                                   |-> osc_reg.hi_en && !osc_reg.lo_sel)
    else $error("not on high clock after reset");

  chk_init_irq: assert property (!SYS_RESET_B |-> CORE_INIT.irq_clear
                                 && CORE_INIT.wdt_enable)
    else $error("core init not driven in reset");

endmodule : rscc_top

// ==== verification/rscc_partner.sv ====
// Model of the far side: reset pin driver, level sources, watchdog, fetch bus, trim bits.
// Assumes the bench calls its tasks from a single process, one at a time.
`timescale 1ns/1ps
module rscc_partner (
  input  wire logic clk,
  output logic        pin_b,
  output logic        por_req,
  output logic        vlt_one,
  output logic        vlt_two,
  output logic        wdt_req,
  output logic        fetch_stb,
  output logic [15:0] fetch_addr,
  output logic [7:0]  trim_data,
  output logic        trim_par
);
  // ==========================================================================
  // Idle levels
  initial begin
    pin_b      = 1'b1;
    por_req    = 1'b0;
    vlt_one    = 1'b0;
    vlt_two    = 1'b0;
    wdt_req    = 1'b0;
    fetch_stb  = 1'b0;
    fetch_addr = 16'hffff;
    trim_data  = 8'h3c;
    trim_par   = 1'b0;
  end
  // ==========================================================================
  // Sources
  task automatic pin_low(input int n);
    @(posedge clk);
    pin_b <= 1'b0;
    repeat (n) @(posedge clk);
    pin_b <= 1'b1;
  endtask : pin_low
  task automatic wdt_pulse();
    @(posedge clk);
    wdt_req <= 1'b1;
    @(posedge clk);
    wdt_req <= 1'b0;
  endtask : wdt_pulse
  // Address is inverted after the strobe so a stale value never looks valid
  task automatic fetch(input logic [15:0] a);
    @(posedge clk);
    fetch_stb  <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    fetch_stb  <= 1'b0;
    fetch_addr <= ~a;
  endtask : fetch
  // Indices 0 to 2 are the level requests, any other index drives the trim parity
  task automatic set_lvl(input int idx, input logic v);
    @(posedge clk);
    case (idx)
      0: por_req <= v;
      1: vlt_one <= v;
      2: vlt_two <= v;
      default: trim_par <= v;
    endcase
  endtask : set_lvl
endmodule : rscc_partner

// ==== verification/reset_source_controller_tb.sv ====
// Self-checking bench of the reset source controller.
// Assumes the design's package and modules are compiled first.
`timescale 1ns/1ps
module reset_source_controller_tb;
  import rscc_pkg::*;
  localparam logic [7:0] A_CAUSE = {REG_IDX_CAUSE, 2'b00};
  localparam logic [7:0] A_TRAP  = {REG_IDX_WDC, 2'b00};
  localparam logic [7:0] A_SYSC  = {REG_IDX_SYSC, 2'b00};
  logic clk, rst_b, rd_en, wr_en, waitreq, sys_rst_b, pin_b, por, v1, v2, wdt, stb, tpar, irq;
  logic [7:0]  addr, tdata, tval, d;
  logic [31:0] wdata, rdata;
  logic [15:0] faddr, vec;
  rscc_init_t  cinit;
  rscc_osc_t   osc;
  int          fail_count, total_checks, n, ev_bit[8];
  // ==========================================================================
  // Design and far side
  rscc_top #(.POWUP_CYC(16)) dut_u (
    .CLK_SYS(clk), .RST_B(rst_b), .CE(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .RESET_PIN_B(pin_b), .POR_REQ(por), .VLT_ONE_REQ(v1),
    .VLT_TWO_REQ(v2), .WDT_REQ(wdt), .FETCH_STROBE(stb), .FETCH_ADDR(faddr),
    .TRIM_DATA(tdata), .TRIM_PARITY(tpar), .SYS_RESET_B(sys_rst_b), .CORE_INIT(cinit),
    .OSC_CTRL(osc), .RESET_VECTOR(vec), .TRIM_VALUE(tval), .ATRAP_IRQ(irq));
  rscc_partner p_u (
    .clk(clk), .pin_b(pin_b), .por_req(por), .vlt_one(v1), .vlt_two(v2), .wdt_req(wdt),
    .fetch_stb(stb), .fetch_addr(faddr), .trim_data(tdata), .trim_par(tpar));
  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end
  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Bus request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
    @(posedge clk);
    rd_en <= ~w;
    wr_en <= w;
    addr  <= a;
    wdata <= {24'h0, wd};
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    d = rdata[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask : bus
  task automatic wait_rst(input logic v, input int maxc);
    n = 0;
    while (sys_rst_b !== v && n < maxc) begin
      @(posedge clk);
      n++;
    end
    // A reset that never comes or never goes ends the run at once
    if (sys_rst_b !== v) begin
      chk("reset_wait", sys_rst_b, v);
      summarize();
    end
  endtask : wait_rst
  task automatic trap_irq(input logic [7:0] ctl, input logic [15:0] a, input int exp);
    int c;
    bus(1'b1, A_TRAP, ctl);
    p_u.fetch(a);
    c = 0;
    repeat (3) begin
      @(posedge clk);
      if (irq === 1'b1) c++;
    end
    chk("trap_irq", c, exp);
    chk("no_reset", sys_rst_b, 1'b1);
  endtask : trap_irq
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // ==========================================================================
  // Tests
  initial begin
    fail_count = 0;
    total_checks = 0;
    ev_bit = '{0, 1, 2, 2, 2, 3, 4, 5};
    rst_b = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr  = 8'h00;
    wdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wait_rst(1'b1, 100);
    chk("warmup", n >= 16 && n <= 20, 1);
    chk("core_init", cinit, 4'h0);
    chk("vector", vec, 16'hfffe);
    chk("osc", osc, 3'b100);
    chk("trim", tval, 8'h3c);
    bus(1'b0, A_CAUSE, 8'h00);
    chk("cause_rst", d, 8'h00);
    bus(1'b1, 8'h10, 8'hff);
    bus(1'b0, 8'h10, 8'h00);
    chk("unmapped", d, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      case (i)
        0: p_u.fetch(16'h0010);
        1: p_u.wdt_pulse();
        2: bus(1'b1, A_SYSC, 8'h00);
        3: bus(1'b1, A_SYSC, 8'h40);
        4: bus(1'b1, A_SYSC, 8'ha0);
        5: p_u.set_lvl(1, 1'b1);
        6: p_u.set_lvl(2, 1'b1);
        default: begin
          // Trim is only read during warm-up, so spoil it and then raise power-on
          p_u.set_lvl(3, 1'b1);
          p_u.set_lvl(0, 1'b1);
          p_u.set_lvl(0, 1'b0);
        end
      endcase
      wait_rst(1'b0, 40);
      chk("enter", n <= 24, 1);
      chk("init_in_rst", cinit, 4'hf);
      chk("osc_run", osc.hi_en, 1'b1);
      p_u.set_lvl(i - 4, 1'b0);
      wait_rst(1'b1, 300);
      bus(1'b0, A_CAUSE, 8'h00);
      chk("cause", d, 8'h01 << ev_bit[i]);
      bus(1'b1, A_CAUSE, 8'h00);
      bus(1'b0, A_CAUSE, 8'h00);
      chk("clr_zero", d, 8'h01 << ev_bit[i]);
      bus(1'b1, A_CAUSE, 8'h80);
      bus(1'b0, A_CAUSE, 8'h00);
      chk("clr_one", d, 8'h00);
    end
    $display("test malfunction sources done");
    p_u.set_lvl(0, 1'b1);
    wait_rst(1'b0, 10);
    p_u.set_lvl(0, 1'b0);
    wait_rst(1'b1, 100);
    chk("por_warmup", n >= 16, 1);
    p_u.wdt_pulse();
    wait_rst(1'b0, 10);
    wait_rst(1'b1, 300);
    p_u.pin_low(12);
    chk("pin_rst", sys_rst_b, 1'b0);
    wait_rst(1'b1, 100);
    chk("pin_osc", {osc.hi_en, osc.lo_sel}, 2'b10);
    bus(1'b0, A_CAUSE, 8'h00);
    chk("pin_clr", d, 8'h00);
    $display("test reset pin done");
    trap_irq(8'h02, 16'h0fa0, 1);
    trap_irq(8'h02, 16'h0100, 0);
    trap_irq(8'h03, 16'h0100, 1);
    trap_irq(8'h06, 16'h0fa0, 0);
    $display("test trap modes done");
    summarize();
  end
endmodule : reset_source_controller_tb
